// File: rtl/alc_pkg.sv
// shared constants and types for the record-path level and volume control
package alc_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_PASS        = 8'h05;
    localparam logic [7:0] IDX_CONV        = 8'h0E;
    localparam logic [7:0] IDX_VOL_L       = 8'h0F;
    localparam logic [7:0] IDX_VOL_R       = 8'h10;
    localparam logic [7:0] IDX_GAIN_BOUNDS = 8'h20;
    localparam logic [7:0] IDX_HOLD_TARGET = 8'h21;
    localparam logic [7:0] IDX_TIMING      = 8'h22;
    localparam logic [7:0] IDX_GATE        = 8'h23;
    localparam logic [7:0] IDX_GAIN_L      = 8'h46;
    localparam logic [7:0] IDX_GAIN_R      = 8'h47;
    localparam logic [7:0] IDX_AVG         = 8'h48;
    localparam logic [7:0] IDX_LVL_PP      = 8'h4C;
    localparam logic [7:0] IDX_LVL_PK      = 8'h4D;
    // field positions
    localparam int FLOOR_LSB = 0;
    localparam int CEIL_LSB  = 3;
    localparam int EN_LSB    = 7;
    localparam int TGT_LSB   = 0;
    localparam int HOLD_LSB  = 4;
    localparam int ATK_LSB   = 0;
    localparam int DCY_LSB   = 4;
    localparam int LIM_BIT   = 8;
    localparam int UPD_BIT   = 8;
    localparam int GEN_BIT   = 3;
    localparam int OSR_BIT   = 3;
    // reset values
    localparam logic [8:0] BOUNDS_RST = 9'h038;
    localparam logic [8:0] HT_RST     = 9'h00B;
    localparam logic [8:0] TIMING_RST = 9'h032;
    localparam logic [8:0] ZERO9      = 9'h000;
    localparam logic [7:0] VOL_RST    = 8'hFF;
    // timing
    localparam int CLK_MHZ     = 100;
    localparam int ATK_NORM_US = 125;
    localparam int ATK_LIM_US  = 31;
    localparam int DCY_NORM_US = 500;
    localparam int DCY_LIM_US  = 125;
    localparam int HOLD_MS     = 1;
    localparam int ATK_NORM_CYC = ATK_NORM_US * CLK_MHZ;
    localparam int ATK_LIM_CYC  = ATK_LIM_US * CLK_MHZ;
    localparam int DCY_NORM_CYC = DCY_NORM_US * CLK_MHZ;
    localparam int DCY_LIM_CYC  = DCY_LIM_US * CLK_MHZ;
    localparam int HOLD_CYC     = HOLD_MS * 1000 * CLK_MHZ;
    localparam logic [3:0] CODE_MAX  = 4'hA;
    localparam logic [6:0] MCLK_LAST = 7'h7F;
    // gain codes in 0.75 dB steps from -12 dB
    localparam logic [5:0] FLOOR_STEP = 6'h08;
    localparam logic [5:0] CEIL_OFS   = 6'h07;
    localparam logic [22:0] EMERG_LVL = 23'h700000;
    localparam logic [22:0] GATE_BASE = 23'h020000;
    localparam logic [7:0]  VOL_MUTE  = 8'h00;
    localparam logic [7:0]  VOL_FULL  = 8'hFF;
    localparam logic [7:0]  HALF_DB_PER_SHIFT = 8'h0C;

    typedef struct packed {
        logic [23:0] l;
        logic [23:0] r;
    } stereo_t;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_ATTACK = 4'b0010,
        ST_HOLD   = 4'b0100,
        ST_DECAY  = 4'b1000
    } alc_state_t;
endpackage

// File: rtl/alc_volume_ctrl.sv
// level control, converter output stage and apb register file
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
// Function
// - one parameter set for both channels, each channel enabled on its own
// - disabled amplifier keeps the last gain the controller gave it
// - enable field bits 7-8: 00 off, 01 right, 10 left, 11 both
// - gain floor bits 0-2, -12 dB upward in 6 dB steps, resets -12 dB
// - gain ceiling bits 3-5, -6.75 to 35.25 dB, resets to 35.25 dB
// - target bits 0-3, -22.5 to -1.5 dBFS in 1.5 dB, reset -6 dBFS
// - hold bits 4-7, 0 ms then doubling, saturating at 1024 ms
// - attack interval per 0.75 dB cut doubles per code, limiter faster
// - decay interval per 0.75 dB rise doubles per code, limiter faster
// - bit 8 selects limiter, effective only with a channel enabled
// - limiter caps gain at the gain in effect when limiter started
// - live readout of left and right applied gain
// - live left-channel peak-to-peak and peak level readouts with averaging choice
// - output samples are 24-bit two's complement
// - sample rate comes only from master clock at 128 times rate
// - modulator at 64x by default or 128x, sample rate unchanged
// - polarity inversion per channel
// - passthrough feeds converter data to playback, ignores external data
// - volume codes 0.5 dB apart, applied in 6 dB steps from 0 to -126 dB, plus a mute code
// - volume write with update bit 0 only becomes pending
// - update bit 1 applies written and pending values together
// - above 87.5 percent full scale cut gain at fastest attack rate
// - above target cut at attack rate until 1.5 dB below target
// - after hold raise at decay rate while 1.5 dB below, up to ceiling
// - normal mode with gate on holds gain while input below threshold
module alc_volume_ctrl #(
    parameter int ATK_NORM_P = alc_pkg::ATK_NORM_CYC,
    parameter int ATK_LIM_P  = alc_pkg::ATK_LIM_CYC,
    parameter int DCY_NORM_P = alc_pkg::DCY_NORM_CYC,
    parameter int DCY_LIM_P  = alc_pkg::DCY_LIM_CYC,
    parameter int HOLD_P     = alc_pkg::HOLD_CYC
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    // apb slave
    input  wire logic [9:0]       paddr_i,
    input  wire logic             psel_i,
    input  wire logic             penable_i,
    input  wire logic             pwrite_i,
    input  wire logic [31:0]      pwdata_i,
    output logic [31:0]           prdata_o,
    output logic                  pready_o,
    output logic                  pslverr_o,
    // decimator samples and playback source
    input  wire logic             sample_valid_i,
    input  wire alc_pkg::stereo_t sample_i,
    input  wire alc_pkg::stereo_t playback_ext_i,
    input  wire logic [1:0]       amp_enable_i,
    // outputs
    output alc_pkg::stereo_t      out_o,
    output logic                  out_valid_o,
    output alc_pkg::stereo_t      playback_o,
    output logic [5:0]            gain_left_o,
    output logic [5:0]            gain_right_o,
    output logic                  sample_tick_o,
    output logic                  mod_tick_o,
    output logic                  mod_128x_o
);
    import alc_pkg::*;

    logic [8:0]  bounds_reg, bounds_next, ht_reg, ht_next, tim_reg, tim_next;
    logic [8:0]  gate_reg, gate_next, conv_reg, conv_next, pass_reg, pass_next;
    logic [8:0]  avg_reg, avg_next;
    logic [7:0]  vol_reg [2], vol_next [2], pend_reg [2], pend_next [2];
    logic [1:0]  pendv_reg, pendv_next;
    logic [31:0] prdata_reg, prdata_next;
    logic [5:0]  gain_reg [2], gain_next [2], cap_reg [2], cap_next [2];
    logic [22:0] peak_reg [2], peak_next [2], pp_reg [2], pp_next [2];
    logic [27:0] tmr_reg [2], tmr_next [2];
    alc_state_t  st_reg [2], st_next [2];
    logic        lim_reg, lim_next;
    logic [6:0]  mclk_reg, mclk_next;
    stereo_t     out_reg, out_next;
    logic        ov_reg, ov_next;
    logic        wr, rd_setup, vol_wr, mapped;
    logic [7:0]  idx;
    logic [1:0]  en;
    logic        lim_act;
    logic [5:0]  floor_g, cap_g [2];
    logic [27:0] atk_int, dcy_int, hold_int;
    logic [22:0] upper, lower;

    // target thresholds in 1.5 dB steps from -24 dBFS, 23-bit magnitude
    function automatic logic [22:0] lvl_tbl(input logic [3:0] i);
        case (i)
            4'h0: lvl_tbl = 23'h081388;  4'h1: lvl_tbl = 23'h0999BF;
            4'h2: lvl_tbl = 23'h0B6871;  4'h3: lvl_tbl = 23'h0D8EFA;
            4'h4: lvl_tbl = 23'h101D4A;  4'h5: lvl_tbl = 23'h1326E9;
            4'h6: lvl_tbl = 23'h16C317;  4'h7: lvl_tbl = 23'h1B0D84;
            4'h8: lvl_tbl = 23'h2026F6;  4'h9: lvl_tbl = 23'h263689;
            4'hA: lvl_tbl = 23'h2D6A84;  4'hB: lvl_tbl = 23'h35FA2C;
            4'hC: lvl_tbl = 23'h4026EA;  4'hD: lvl_tbl = 23'h4C3EA8;
            4'hE: lvl_tbl = 23'h5A9DF7;  default: lvl_tbl = 23'h6BB2D7;
        endcase
    endfunction

    function automatic logic [22:0] mag(input logic [23:0] s);
        mag = (s == 24'h800000) ? 23'h7FFFFF : s[23] ? 23'(~s + 24'h000001) : s[22:0];
    endfunction

    // apb decode; zero wait states, stalled while the clock enable is low
    assign idx      = paddr_i[9:2];
    assign wr       = psel_i & penable_i & pwrite_i & ce_i;
    assign rd_setup = psel_i & ~penable_i & ce_i;
    assign pready_o = ce_i;
    assign prdata_o = prdata_reg;
    assign vol_wr   = wr & (idx == IDX_VOL_L || idx == IDX_VOL_R);
    always_comb begin
        unique case (idx)
            IDX_PASS, IDX_CONV, IDX_VOL_L, IDX_VOL_R, IDX_GAIN_BOUNDS,
            IDX_HOLD_TARGET, IDX_TIMING, IDX_GATE, IDX_GAIN_L, IDX_GAIN_R,
            IDX_AVG, IDX_LVL_PP, IDX_LVL_PK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign pslverr_o = psel_i & penable_i & ~mapped;

    // shared controls for both channels; limiter needs an enabled channel
    assign en      = bounds_reg[EN_LSB +: 2];
    assign lim_act = tim_reg[LIM_BIT] & (|en);
    assign floor_g = 6'(bounds_reg[FLOOR_LSB +: 3] * FLOOR_STEP);
    assign upper   = (ht_reg[TGT_LSB +: 4] == 4'hF) ? lvl_tbl(4'hF)
                                                    : lvl_tbl(ht_reg[TGT_LSB +: 4] + 4'h1);
    assign lower   = lvl_tbl(ht_reg[TGT_LSB +: 4]); // 1.5 dB below target
    always_comb begin
        logic [3:0] a, d, h;
        a = (tim_reg[ATK_LSB +: 4] > CODE_MAX) ? CODE_MAX : tim_reg[ATK_LSB +: 4];
        d = (tim_reg[DCY_LSB +: 4] > CODE_MAX) ? CODE_MAX : tim_reg[DCY_LSB +: 4];
        h = (ht_reg[HOLD_LSB +: 4] > CODE_MAX) ? CODE_MAX : ht_reg[HOLD_LSB +: 4];
        atk_int  = (lim_act ? 28'(ATK_LIM_P) : 28'(ATK_NORM_P)) << a;
        dcy_int  = (lim_act ? 28'(DCY_LIM_P) : 28'(DCY_NORM_P)) << d;
        hold_int = (h == 4'h0) ? 28'h0000000 : 28'(HOLD_P) << h;
        for (int c = 0; c < 2; c++) begin
            cap_g[c] = lim_act ? cap_reg[c]
                     : 6'(bounds_reg[CEIL_LSB +: 3] * FLOOR_STEP) + CEIL_OFS;
        end
    end

    // register writes, volume staging and read capture
    always_comb begin
        logic [8:0] w;
        logic       c;
        w = pwdata_i[8:0];
        c = (idx == IDX_VOL_R);
        bounds_next = bounds_reg;
        ht_next     = ht_reg;
        tim_next    = tim_reg;
        gate_next   = gate_reg;
        conv_next   = conv_reg;
        pass_next   = pass_reg;
        avg_next    = avg_reg;
        vol_next    = vol_reg;
        pend_next   = pend_reg;
        pendv_next  = pendv_reg;
        prdata_next = prdata_reg;
        if (wr) begin
            unique case (idx)
                IDX_GAIN_BOUNDS: bounds_next = w;
                IDX_HOLD_TARGET: ht_next = w;
                IDX_TIMING:      tim_next = w;
                IDX_GATE:        gate_next = w;
                IDX_CONV:        conv_next = w;
                IDX_PASS:        pass_next = w;
                IDX_AVG:         avg_next = w;
                default:         ;
            endcase
        end
        if (vol_wr && !w[UPD_BIT]) begin
            pend_next[c]  = w[7:0];
            pendv_next[c] = 1'b1;
        end else if (vol_wr) begin
            vol_next[c] = w[7:0];
            if (pendv_reg[~c]) begin
                vol_next[~c] = pend_reg[~c];
            end
            pendv_next = 2'b00;
        end
        if (rd_setup) begin
            unique case (idx)
                IDX_GAIN_BOUNDS: prdata_next = {23'h0, bounds_reg};
                IDX_HOLD_TARGET: prdata_next = {23'h0, ht_reg};
                IDX_TIMING:      prdata_next = {23'h0, tim_reg};
                IDX_GATE:        prdata_next = {23'h0, gate_reg};
                IDX_CONV:        prdata_next = {23'h0, conv_reg};
                IDX_PASS:        prdata_next = {23'h0, pass_reg};
                IDX_AVG:         prdata_next = {23'h0, avg_reg};
                IDX_VOL_L:       prdata_next = {24'h0, vol_reg[0]};
                IDX_VOL_R:       prdata_next = {24'h0, vol_reg[1]};
                IDX_GAIN_L:      prdata_next = {26'h0, gain_reg[0]};
                IDX_GAIN_R:      prdata_next = {26'h0, gain_reg[1]};
                IDX_LVL_PP:      prdata_next = {9'h0, pp_reg[0]};
                IDX_LVL_PK:      prdata_next = {9'h0, peak_reg[0]};
                default:         prdata_next = 32'h00000000;
            endcase
        end
    end

    // level detectors and gain state machines, one pass per channel
    always_comb begin
        logic [22:0] m, gthr;
        logic        emerg, over, under, quiet, hold_g;
        m        = 23'h000000;
        gthr     = 23'h000000;
        emerg    = 1'b0;
        over     = 1'b0;
        under    = 1'b0;
        quiet    = 1'b0;
        hold_g   = 1'b0;
        lim_next = lim_act;
        for (int c = 0; c < 2; c++) begin
            m         = mag(c == 0 ? out_reg.l : out_reg.r);
            peak_next[c] = peak_reg[c];
            pp_next[c]   = pp_reg[c];
            if (ov_reg) begin
                // peak holds new maxima and leaks away otherwise
                peak_next[c] = (m > peak_reg[c]) ? m
                             : peak_reg[c] - (peak_reg[c] >> ({1'b0, avg_reg[1:0]} + 3'h1));
                // signed step so a falling level pulls the average down, not up
                pp_next[c]   = pp_reg[c] + 23'($signed({1'b0, m, 1'b0} - {2'b00, pp_reg[c]})
                             >>> ({1'b0, avg_reg[3:2]} + 3'h2));
            end
            emerg = m > EMERG_LVL;
            over  = peak_reg[c] > upper;
            under = peak_reg[c] < lower;
            gthr  = GATE_BASE >> gate_reg[2:0];
            quiet = (peak_reg[c] >> gain_reg[c][5:3]) < gthr;
            hold_g = ~lim_act & gate_reg[GEN_BIT] & quiet;
            cap_next[c] = (lim_act && !lim_reg) ? gain_reg[c] : cap_reg[c];
            gain_next[c] = gain_reg[c];
            st_next[c]   = st_reg[c];
            tmr_next[c]  = tmr_reg[c] + 28'h0000001;
            if (!en[(c == 0) ? 1 : 0] || !amp_enable_i[c]) begin
                st_next[c]  = ST_IDLE; // gain frozen
                tmr_next[c] = 28'h0000000;
            end else begin
                unique case (st_reg[c])
                    ST_IDLE: begin
                        tmr_next[c] = 28'h0000000;
                        if (emerg || over) begin
                            st_next[c] = ST_ATTACK;
                        end else if (under && !hold_g) begin
                            st_next[c] = ST_HOLD;
                        end
                    end
                    ST_ATTACK: begin
                        if (tmr_reg[c] >= (emerg ? 28'(ATK_LIM_P) : atk_int)) begin
                            tmr_next[c] = 28'h0000000;
                            if (gain_reg[c] > floor_g) begin
                                gain_next[c] = gain_reg[c] - 6'h01;
                            end
                        end
                        if (under && !emerg) begin
                            st_next[c] = ST_IDLE;
                        end
                    end
                    ST_HOLD: begin
                        if (emerg || !under || hold_g) begin
                            st_next[c] = ST_IDLE;
                        end else if (tmr_reg[c] >= hold_int) begin
                            st_next[c]  = ST_DECAY;
                            tmr_next[c] = 28'h0000000;
                        end
                    end
                    ST_DECAY: begin
                        if (emerg || !under || hold_g) begin
                            st_next[c] = ST_IDLE;
                        end else if (tmr_reg[c] >= dcy_int) begin
                            tmr_next[c] = 28'h0000000;
                            if (gain_reg[c] < cap_g[c]) begin
                                gain_next[c] = gain_reg[c] + 6'h01;
                            end
                        end
                    end
                endcase
                // gain below a raised floor climbs back one step
                if (gain_next[c] < floor_g) begin
                    gain_next[c] = gain_reg[c] + 6'h01;
                end
            end
        end
    end

    // output stage: inversion, volume, passthrough; rate timing
    always_comb begin
        logic [23:0] s;
        logic [7:0]  sh;
        s         = 24'h000000;
        sh        = 8'h00;
        out_next  = out_reg;
        ov_next   = sample_valid_i;
        mclk_next = mclk_reg + 7'h01;
        for (int c = 0; c < 2; c++) begin
            s  = (c == 0) ? sample_i.l : sample_i.r;
            s  = conv_reg[c] ? 24'(~s + 24'h000001) : s;
            sh = (VOL_FULL - vol_reg[c]) / HALF_DB_PER_SHIFT; // 6 dB per shift
            s  = (vol_reg[c] == VOL_MUTE) ? 24'h000000 : 24'($signed(s) >>> sh);
            if (sample_valid_i && c == 0) begin
                out_next.l = s;
            end else if (sample_valid_i) begin
                out_next.r = s;
            end
        end
    end
    assign out_o         = out_reg;
    assign out_valid_o   = ov_reg;
    assign playback_o    = pass_reg[0] ? out_reg : playback_ext_i;
    assign gain_left_o   = gain_reg[0];
    assign gain_right_o  = gain_reg[1];
    assign sample_tick_o = ce_i & (mclk_reg == MCLK_LAST);
    assign mod_128x_o    = conv_reg[OSR_BIT];
    assign mod_tick_o    = ce_i & (conv_reg[OSR_BIT] | mclk_reg[0]);

    // all state registers; everything freezes while ce_i is low
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bounds_reg <= BOUNDS_RST;
            ht_reg     <= HT_RST;
            tim_reg    <= TIMING_RST;
            gate_reg   <= ZERO9;
            conv_reg   <= ZERO9;
            pass_reg   <= ZERO9;
            avg_reg    <= ZERO9;
            pendv_reg  <= 2'b00;
            prdata_reg <= 32'h00000000;
            lim_reg    <= 1'b0;
            mclk_reg   <= 7'h00;
            out_reg    <= '0;
            ov_reg     <= 1'b0;
            for (int c = 0; c < 2; c++) begin
                vol_reg[c]  <= VOL_RST;
                pend_reg[c] <= VOL_RST;
                gain_reg[c] <= 6'h00;
                cap_reg[c]  <= 6'h00;
                peak_reg[c] <= 23'h000000;
                pp_reg[c]   <= 23'h000000;
                tmr_reg[c]  <= 28'h0000000;
                st_reg[c]   <= ST_IDLE;
            end
        end else if (ce_i) begin
            bounds_reg <= bounds_next;
            ht_reg     <= ht_next;
            tim_reg    <= tim_next;
            gate_reg   <= gate_next;
            conv_reg   <= conv_next;
            pass_reg   <= pass_next;
            avg_reg    <= avg_next;
            pendv_reg  <= pendv_next;
            prdata_reg <= prdata_next;
            lim_reg    <= lim_next;
            mclk_reg   <= mclk_next;
            out_reg    <= out_next;
            ov_reg     <= ov_next;
            vol_reg    <= vol_next;
            pend_reg   <= pend_next;
            gain_reg   <= gain_next;
            cap_reg    <= cap_next;
            peak_reg   <= peak_next;
            pp_reg     <= pp_next;
            tmr_reg    <= tmr_next;
            st_reg     <= st_next;
        end
    end

    // checks and scenario coverage
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_gain_floor_hold: assert property (ce_i && gain_next[0] < gain_reg[0]
        |-> gain_next[0] >= floor_g) else $error("gain cut below floor");
    a_gain_cap_hold: assert property (ce_i && gain_next[1] > gain_reg[1]
        |-> gain_next[1] <= cap_g[1]) else $error("gain raised past cap");
    a_amp_off_freeze: assert property (ce_i && !amp_enable_i[0]
        |=> gain_reg[0] == $past(gain_reg[0])) else $error("gain moved off");
    a_en_off_freeze: assert property (ce_i && en == 2'b00 ##1 ce_i && en == 2'b00
        |=> $stable(gain_reg[1])) else $error("gain moved while disabled");
    a_vol_pend_keep: assert property (vol_wr && !pwdata_i[UPD_BIT]
        |=> $stable(vol_reg[0]) && $stable(vol_reg[1])) else $error("pending applied");
    a_vol_upd_apply: assert property (vol_wr && pwdata_i[UPD_BIT] && idx == IDX_VOL_L
        |=> vol_reg[0] == $past(pwdata_i[7:0])) else $error("update lost");
    a_emerg_attack: assert property (ce_i && en[1] && amp_enable_i[0]
        && st_reg[0] == ST_IDLE && mag(out_reg.l) > EMERG_LVL
        |=> st_reg[0] == ST_ATTACK) else $error("no emergency attack");
    a_lim_cap_keep: assert property (ce_i && lim_act && lim_reg && gain_next[0] > gain_reg[0]
        |-> gain_next[0] <= cap_reg[0]) else $error("limiter cap broken");
    a_tick_spacing: assert property (sample_tick_o |=> !sample_tick_o [*8])
        else $error("sample ticks too close");
    a_pass_route: assert property (pass_reg[0] |-> playback_o == out_o)
        else $error("passthrough not routed");
    c_attack_step: cover property (st_reg[0] == ST_ATTACK ##1 gain_reg[0] < $past(gain_reg[0]));
    c_decay_step: cover property (st_reg[1] == ST_DECAY ##1 gain_reg[1] > $past(gain_reg[1]));
    c_vol_sync: cover property (vol_wr && pwdata_i[UPD_BIT] && pendv_reg != 2'b00);
    c_lim_entry: cover property (lim_act && !lim_reg && ce_i);
endmodule // alc_volume_ctrl

// File: verification/sample_source.sv
// decimator-side model that hands sample pairs to the block
`timescale 1ns/1ns
module sample_source (
    // clock
    input  wire logic        clk_i,
    // sample stream
    output logic             sample_valid_o,
    output alc_pkg::stereo_t sample_o
);
    initial begin
        sample_valid_o = 1'b0;
        sample_o       = '0;
    end
    // one-cycle pulse; data is scrambled afterwards so stale values cannot pass
    task automatic push(input alc_pkg::stereo_t v);
        @(posedge clk_i);
        sample_valid_o <= 1'b1;
        sample_o       <= v;
        @(posedge clk_i);
        sample_valid_o <= 1'b0;
        sample_o       <= ~v;
    endtask
endmodule // sample_source

// File: verification/alc_volume_ctrl_bench.sv
// self-checking bench for the record-path level and volume control
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module alc_volume_ctrl_bench;
    import alc_pkg::*;
    logic        clk_i, rst_i, psel, penable, pwrite, pready, pslverr;
    logic        ov, st, m128, sv, serr, ce, mt;
    logic [1:0]  amp;
    logic [5:0]  gl, gr, g, h;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    stereo_t     smp, ext, outs, pb, s0;
    int          err_total, compares, n;

    // short interval parameters keep the level loop active within the run
    alc_volume_ctrl #(.ATK_NORM_P(8), .ATK_LIM_P(4), .DCY_NORM_P(16), .DCY_LIM_P(8),
        .HOLD_P(16)) i_alc_volume_ctrl (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .sample_valid_i(sv), .sample_i(smp),
        .playback_ext_i(ext), .amp_enable_i(amp), .out_o(outs), .out_valid_o(ov),
        .playback_o(pb), .gain_left_o(gl), .gain_right_o(gr), .sample_tick_o(st),
        .mod_tick_o(mt), .mod_128x_o(m128));
    sample_source i_sample_source (.clk_i(clk_i), .sample_valid_o(sv), .sample_o(smp));

    task automatic summarize();
        if (err_total == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // one apb transfer; an edge passes first so the previous release never collides
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge clk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n >= 64) begin
            err_total++;
            summarize();
        end
        rd = prdata;
        serr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic send(input stereo_t v);
        i_sample_source.push(v);
        @(negedge clk_i);
        `CHK(ov, 1'b1)
    endtask

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        rst_i = 1'b1;
        ce = 1'b1;
        amp = 2'b11;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        err_total = 0;
        compares = 0;
        ext = 48'h5A5A5A_A5A5A5;
        s0 = {24'h123456, 24'hFEDCBA};
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        // defaults after reset
        bus(1'b0, IDX_GAIN_BOUNDS, '0);
        `CHK(rd, {23'h0, BOUNDS_RST})
        bus(1'b0, IDX_HOLD_TARGET, '0);
        `CHK(rd, {23'h0, HT_RST})
        bus(1'b0, IDX_TIMING, '0);
        `CHK(rd, {23'h0, TIMING_RST})
        bus(1'b0, IDX_GAIN_L, '0);
        `CHK(rd, 32'h0)
        bus(1'b0, IDX_VOL_L, '0);
        `CHK(rd, {24'h0, VOL_RST})
        // only the nine low bits hold, upper bits read back zero
        bus(1'b1, IDX_GAIN_BOUNDS, 32'hFFFF_FFFF);
        bus(1'b0, IDX_GAIN_BOUNDS, '0);
        `CHK(rd, 32'h0000_01FF)
        bus(1'b1, IDX_GAIN_BOUNDS, {23'h0, BOUNDS_RST});
        bus(1'b0, 8'h01, '0);
        `CHK(serr, 1'b1)
        `CHK(rd, 32'h0)
        // plain path, then passthrough
        send(s0);
        `CHK(outs, s0)
        `CHK(pb, ext)
        bus(1'b1, IDX_PASS, 32'h1);
        send(s0);
        `CHK(pb, s0)
        bus(1'b1, IDX_PASS, 32'h0);
        // both polarities inverted, then the faster modulator
        bus(1'b1, IDX_CONV, 32'h3);
        send(s0);
        `CHK(outs, {24'hEDCBAA, 24'h012346})
        `CHK(m128, 1'b0)
        bus(1'b1, IDX_CONV, 32'h8);
        repeat (2) @(negedge clk_i);
        `CHK(m128, 1'b1)
        `CHK(mt, 1'b1)
        // pending volume, then update applies both channels together
        bus(1'b1, IDX_VOL_L, 32'h080);
        bus(1'b0, IDX_VOL_L, '0);
        `CHK(rd, 32'hFF)
        bus(1'b1, IDX_VOL_R, 32'h140);
        bus(1'b0, IDX_VOL_L, '0);
        `CHK(rd, 32'h80)
        bus(1'b0, IDX_VOL_R, '0);
        `CHK(rd, 32'h40)
        bus(1'b1, IDX_VOL_L, 32'h100);
        send(s0);
        `CHK(outs.l, 24'h0)
        // left level control only: decay rise, freezes, limiter cap, emergency cut
        bus(1'b1, IDX_GAIN_BOUNDS, 32'h138);
        repeat (300) @(posedge clk_i);
        ce <= 1'b0;
        @(negedge clk_i);
        g = gl;
        h = gr;
        `CHK(pready, 1'b0)
        repeat (300) @(negedge clk_i);
        `CHK(gl, g)
        `CHK(g > 6'h06, 1'b1)
        @(posedge clk_i);
        ce  <= 1'b1;
        amp <= 2'b10;
        repeat (300) @(negedge clk_i);
        `CHK(gl, g)
        bus(1'b0, IDX_GAIN_L, '0);
        `CHK(rd, {26'h0, g})
        amp <= 2'b11;
        bus(1'b1, IDX_TIMING, 32'h132);
        bus(1'b1, IDX_VOL_L, 32'h1FF);
        send({24'h7FFFFF, 24'h000000});
        repeat (100) @(negedge clk_i);
        `CHK(gl, 6'h00)
        send('0);
        send('0);
        repeat (1000) @(negedge clk_i);
        `CHK(gl, g)
        `CHK(gr, h)
        // a reset in mid-run drops a pending volume
        bus(1'b1, IDX_VOL_R, 32'h020);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b1, IDX_VOL_L, 32'h1FF);
        bus(1'b0, IDX_VOL_R, '0);
        `CHK(rd, {24'h0, VOL_RST})
        // sample rate tick spacing
        n = 0;
        while (st !== 1'b1 && n < 300) begin
            @(negedge clk_i);
            n++;
        end
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (st !== 1'b1 && n < 300);
        `CHK(n, 128)
        summarize();
    end
endmodule // alc_volume_ctrl_bench
